// File: rtl/drive_ctrl_cfg.svh
// Register map, field positions, reset values and timing counts of the drive control block
// Overview of operation
// (R01) Hardware enable LOW inhibits, HIGH enables; no motor start without enable.
// (R02) Basic variant accepts parameter writes only while inhibited; extended variant always.
// (R03) With keypad attached, hardware enable and keypad run latch act in series.
// (R04) Keypad stop then keypad removal keeps inhibit until power cycle or RUN press.
// (R05) Under serial control the software enable parameter must also be set.
// (R06) Command word enable bit is an alternative software enable source.
// (R07) Flying restart measures coasting speed first, then ramps from it to setpoint.
// (R08) Auto start inhibited: no power after power-up or fault until enable rises.
// (R09) Start option: 0 inhibit, 1 auto, 2 inhibit plus flying, 3 auto; default 1.
// (R10) Configurations 0 to 13 take direction from input four alone.
// (R11) Configurations 14 to 22: input three clockwise, four counterclockwise, both LOW quickstop.
// (R12) Both HIGH: no reversal, first input keeps direction; at power-on quickstop.
// (R13) Output setpoint is always limited to the maximum frequency.
// (R14) Frequency setpoint ranges 0 to 480.0 Hz basic, to maximum extended; default 0.
// (R15) Extended clamps written setpoint to maximum; basic stores it unchanged.
// (R16) Motor potentiometer active only in configurations 10, 11, 12, 13 and 21.
// (R17) Inputs one/two: both LOW zero, one down, two up, both freeze.
// (R18) Motor potentiometer value kept nonvolatile across power-off, inhibit and trip.
// (R19) Extended variant: quickstop resets the motor potentiometer value to 0 Hz.
// (R20) Command word is a 16-bit bitmapped control parameter with enable bit.
// (R21) Run permission is hardware enable AND keypad latch AND software enable.
`ifndef DRIVE_CTRL_CFG_SVH
`define DRIVE_CTRL_CFG_SVH

`define REG_CTRL 6'h00
`define REG_START_OPT 6'h01
`define REG_TERM_CFG 6'h02
`define REG_FMAX 6'h03
`define REG_FMIN 6'h04
`define REG_FSET 6'h05
`define REG_CMD_WORD 6'h06
`define REG_STATUS 6'h07
`define REG_MPOT 6'h08

`define CTRL_EXT_BIT 0
`define CTRL_SERIAL_BIT 1
`define CTRL_SW_EN_BIT 2
`define CMD_ENABLE_BIT 9

`define START_OPT_RST 2'h1
`define START_OPT_FLYING 2'h2
`define FMAX_RST 13'h01f4
`define FMIN_RST 13'h0000
`define FSET_RST 13'h0000
`define FREQ_BASIC_MAX 13'h12c0
`define FREQ_STEP 13'h0001
`define CFG_DIR_ONLY_MAX 5'h0d
`define CFG_LAST 5'h16

`define CLK_PERIOD_NS 40
`define MPOT_STEP_NS 1000000
`define MPOT_STEP_CYC (`MPOT_STEP_NS / `CLK_PERIOD_NS)

`endif

// File: rtl/drive_ctrl_pkg.sv
// Types shared by the drive control block
package drive_ctrl_pkg;

	typedef enum logic [1:0] {
		ST_STOP,
		ST_CATCH,
		ST_RUN
	} run_mode_e;

	typedef struct packed {
		logic ctrl_ext;
		logic serial_ctrl;
		logic sw_en;
		logic [1:0] start_opt;
		logic [4:0] term_cfg;
		logic [12:0] fmax;
		logic [12:0] fmin;
		logic [12:0] fset;
		logic [15:0] command_word;
		logic kp_run;
		logic armed;
		logic hw_en_d;
		logic dir_ccw;
		logic dir_seen;
		logic qstop;
		logic [12:0] mpot;
		logic nv_loaded;
		logic [15:0] tick_cnt;
		run_mode_e mode;
		logic [12:0] catch_speed;
		logic [12:0] setpoint;
		logic a_wr;
		logic [5:0] a_idx;
		logic [31:0] rdata;
	} drive_state_s;

endpackage

// File: rtl/drive_run_enable_setpoint_ctrl.sv
// Run permission, start options, direction and setpoint logic with AHB-Lite registers
`include "drive_ctrl_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module drive_run_enable_setpoint_ctrl #(
	parameter logic [15:0] STEP_CYCLES = 16'(`MPOT_STEP_CYC)
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic hw_enable,
	input wire logic input_one,
	input wire logic input_two,
	input wire logic input_three,
	input wire logic input_four,
	input wire logic keypad_present,
	input wire logic key_run,
	input wire logic key_stop,
	input wire logic fault_trip,
	input wire logic speed_valid,
	input wire logic [12:0] speed_meas,
	input wire logic [12:0] nv_mpot_in,
	output logic [12:0] nv_mpot_out,
	output logic motor_run,
	output logic speed_catch_req,
	output logic [12:0] ramp_start_freq,
	output logic dir_ccw,
	output logic quickstop,
	output logic [12:0] setpoint_out
);

	localparam drive_ctrl_pkg::drive_state_s RST_VAL = '{
		ctrl_ext: 1'b0,
		serial_ctrl: 1'b0,
		sw_en: 1'b0,
		start_opt: `START_OPT_RST,
		term_cfg: 5'h00,
		fmax: `FMAX_RST,
		fmin: `FMIN_RST,
		fset: `FSET_RST,
		command_word: 16'h0000,
		kp_run: 1'b1,
		armed: 1'b0,
		hw_en_d: 1'b0,
		dir_ccw: 1'b0,
		dir_seen: 1'b0,
		qstop: 1'b0,
		mpot: 13'h0000,
		nv_loaded: 1'b0,
		tick_cnt: 16'h0000,
		mode: drive_ctrl_pkg::ST_STOP,
		catch_speed: 13'h0000,
		setpoint: 13'h0000,
		a_wr: 1'b0,
		a_idx: 6'h00,
		rdata: 32'h0000_0000
	};

	drive_ctrl_pkg::drive_state_s s;
	drive_ctrl_pkg::drive_state_s n;

	logic hw_rise;
	logic sw_ok;
	logic enable_chain;
	logic permit;
	logic param_ok;
	logic q_now;
	logic tick;
	logic mpot_active;
	logic [12:0] src;
	logic [12:0] wval;

	// Parameter registers, guarded in the basic variant against writes while the drive is enabled
	function automatic logic is_param(input logic [5:0] idx);
		is_param = (idx == `REG_START_OPT) || (idx == `REG_TERM_CFG) || (idx == `REG_FMAX) ||
			(idx == `REG_FMIN) || (idx == `REG_FSET);
	endfunction

	function automatic logic cfg_in(input logic [4:0] cfg, input logic [4:0] lo,
			input logic [4:0] hi);
		cfg_in = (cfg >= lo) && (cfg <= hi);
	endfunction

	function automatic logic [31:0] read_mux(input drive_ctrl_pkg::drive_state_s st,
			input logic [5:0] idx, input logic chain, input logic perm);
		read_mux = 32'h0000_0000;
		case (idx)
			`REG_CTRL: begin
				read_mux[`CTRL_EXT_BIT] = st.ctrl_ext;
				read_mux[`CTRL_SERIAL_BIT] = st.serial_ctrl;
				read_mux[`CTRL_SW_EN_BIT] = st.sw_en;
			end
			`REG_START_OPT: read_mux[1:0] = st.start_opt;
			`REG_TERM_CFG: read_mux[4:0] = st.term_cfg;
			`REG_FMAX: read_mux[12:0] = st.fmax;
			`REG_FMIN: read_mux[12:0] = st.fmin;
			`REG_FSET: read_mux[12:0] = st.fset;
			`REG_CMD_WORD: read_mux[15:0] = st.command_word;
			`REG_STATUS: read_mux[9:0] = {st.mode, st.dir_seen, st.armed, st.kp_run, st.qstop,
				st.dir_ccw, perm, chain, st.nv_loaded};
			`REG_MPOT: read_mux[12:0] = st.mpot;
			default: read_mux = 32'h0000_0000;
		endcase
	endfunction

	always_comb begin
		n = s;
		hw_rise = hw_enable & ~s.hw_en_d;
		n.hw_en_d = hw_enable;
		// Software enable only counts while the serial module is in charge
		sw_ok = ~s.serial_ctrl | s.sw_en | s.command_word[`CMD_ENABLE_BIT]; // see (R05) (R06)
		enable_chain = hw_enable & s.kp_run & sw_ok; // see (R01) (R21)
		param_ok = s.ctrl_ext | ~enable_chain; // see (R02)
		permit = enable_chain & (s.start_opt[0] | s.armed) & ~fault_trip; // see (R08) (R09)
		wval = (hwdata[31:13] != 19'h0) ? 13'h1fff : hwdata[12:0];

		// Bus address phase; read data is prepared here so it leaves a flip-flop
		n.a_wr = 1'b0;
		if (hready && hsel && htrans[1]) begin
			n.a_wr = hwrite;
			n.a_idx = haddr[7:2];
			n.rdata = read_mux(s, haddr[7:2], enable_chain, permit);
		end

		// Bus data phase
		if (s.a_wr && (param_ok || !is_param(s.a_idx))) begin
			case (s.a_idx)
				`REG_CTRL: begin
					n.ctrl_ext = hwdata[`CTRL_EXT_BIT];
					n.serial_ctrl = hwdata[`CTRL_SERIAL_BIT];
					if (param_ok) begin
						n.sw_en = hwdata[`CTRL_SW_EN_BIT]; // see (R02) (R05)
					end
				end
				`REG_START_OPT: n.start_opt = hwdata[1:0]; // see (R09)
				`REG_TERM_CFG: n.term_cfg = (hwdata[4:0] > `CFG_LAST) ? s.term_cfg : hwdata[4:0];
				`REG_FMAX: n.fmax = (wval > `FREQ_BASIC_MAX) ? `FREQ_BASIC_MAX : wval;
				`REG_FMIN: n.fmin = wval;
				`REG_FSET: begin
					// Basic variant keeps an over-range value; the output limit still holds
					if (s.ctrl_ext && wval > s.fmax) begin
						n.fset = s.fmax; // see (R14) (R15)
					end else begin
						n.fset = wval; // see (R15)
					end
				end
				`REG_CMD_WORD: n.command_word = hwdata[15:0]; // see (R20)
				default: n.command_word = s.command_word;
			endcase
		end

		// Keypad run latch in series with the hardware enable
		if (key_stop && keypad_present) begin
			n.kp_run = 1'b0; // see (R03)
		end else if (keypad_present && !hw_enable) begin
			n.kp_run = 1'b0; // see (R03)
		end else if (key_run && keypad_present && hw_enable) begin
			n.kp_run = 1'b1; // see (R03) (R04)
		end

		// Auto start inhibited: arm only on an enable edge, disarm on a fault
		if (fault_trip) begin
			n.armed = 1'b0; // see (R08)
		end else if (hw_rise) begin
			n.armed = 1'b1; // see (R08)
		end

		// Direction and quickstop decode
		q_now = 1'b0;
		if (s.term_cfg <= `CFG_DIR_ONLY_MAX) begin
			n.dir_ccw = input_four; // see (R10)
			q_now = ~input_three && (s.term_cfg == 5'h02 || s.term_cfg == 5'h04 ||
				s.term_cfg == 5'h08 || s.term_cfg == 5'h09 || s.term_cfg == 5'h0d);
		end else begin
			case ({input_three, input_four})
				2'b10: begin
					n.dir_ccw = 1'b0; // see (R11)
					n.dir_seen = 1'b1;
				end
				2'b01: begin
					n.dir_ccw = 1'b1; // see (R11)
					n.dir_seen = 1'b1;
				end
				2'b00: q_now = 1'b1; // see (R11)
				// Both HIGH hold the earlier direction; never seen one means power-on
				2'b11: q_now = ~s.dir_seen; // see (R12)
				default: q_now = 1'b1;
			endcase
		end
		n.qstop = q_now;

		// Run sequencing
		case (s.mode)
			drive_ctrl_pkg::ST_STOP: begin
				if (permit && !q_now) begin
					if (s.start_opt == `START_OPT_FLYING) begin
						n.mode = drive_ctrl_pkg::ST_CATCH; // see (R07)
					end else begin
						n.mode = drive_ctrl_pkg::ST_RUN;
						n.catch_speed = 13'h0000;
					end
				end
			end
			drive_ctrl_pkg::ST_CATCH: begin
				if (!permit || q_now) begin
					n.mode = drive_ctrl_pkg::ST_STOP;
				end else if (speed_valid) begin
					n.catch_speed = speed_meas; // see (R07)
					n.mode = drive_ctrl_pkg::ST_RUN;
				end
			end
			drive_ctrl_pkg::ST_RUN: begin
				if (!permit || q_now) begin
					n.mode = drive_ctrl_pkg::ST_STOP; // see (R01)
				end
			end
			default: n.mode = drive_ctrl_pkg::ST_STOP;
		endcase

		// Ramp step tick for the motor potentiometer
		tick = (s.tick_cnt >= STEP_CYCLES - 16'h0001);
		n.tick_cnt = tick ? 16'h0000 : s.tick_cnt + 16'h0001;

		mpot_active = cfg_in(s.term_cfg, 5'h0a, 5'h0d) || (s.term_cfg == 5'h15); // see (R16)
		if (!s.nv_loaded) begin
			// Value lives in external storage, restored once after reset
			n.mpot = nv_mpot_in; // see (R18)
			n.nv_loaded = 1'b1;
		end else if (s.ctrl_ext && q_now) begin
			n.mpot = 13'h0000; // see (R19)
		end else if (mpot_active) begin
			case ({input_two, input_one})
				2'b00: n.mpot = 13'h0000; // see (R17)
				2'b01: begin
					if (tick && s.mpot > s.fmin) begin
						n.mpot = s.mpot - `FREQ_STEP; // see (R16) (R17)
					end
				end
				2'b10: begin
					if (tick && s.mpot < s.fmax) begin
						n.mpot = s.mpot + `FREQ_STEP; // see (R16) (R17)
					end
				end
				default: n.mpot = s.mpot;
			endcase
		end

		src = mpot_active ? s.mpot : s.fset;
		n.setpoint = (src > s.fmax) ? s.fmax : src; // see (R13)
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s <= RST_VAL;
		end else begin
			s <= n;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.rdata;
	assign nv_mpot_out = s.mpot;
	assign motor_run = (s.mode == drive_ctrl_pkg::ST_RUN);
	assign speed_catch_req = (s.mode == drive_ctrl_pkg::ST_CATCH);
	assign ramp_start_freq = s.catch_speed;
	assign dir_ccw = s.dir_ccw;
	assign quickstop = s.qstop;
	assign setpoint_out = s.setpoint;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence seq_catch_done;
		s.mode == drive_ctrl_pkg::ST_CATCH && speed_valid && permit && !q_now;
	endsequence

	sequence seq_run_from_speed;
		s.mode == drive_ctrl_pkg::ST_RUN && s.catch_speed == $past(speed_meas);
	endsequence

	chk_enable_low_stops: assert property (!hw_enable |=> !motor_run) // see (R01)
		else $error("motor runs after enable low");
	chk_basic_param_lock: assert property (!s.ctrl_ext && enable_chain && s.a_wr &&
		s.a_idx == `REG_FSET |=> $stable(s.fset)) // see (R02)
		else $error("setpoint written while enabled");
	chk_keypad_stop_latch: assert property (keypad_present && key_stop |=> !s.kp_run ##1
		(!s.kp_run || $past(key_run))) // see (R03)
		else $error("keypad stop not latched");
	chk_sw_enable_gate: assert property (s.serial_ctrl && !s.sw_en &&
		!s.command_word[`CMD_ENABLE_BIT] |=> !motor_run) // see (R05)
		else $error("runs without software enable");
	chk_flying_catch: assert property (seq_catch_done |=> seq_run_from_speed) // see (R07)
		else $error("flying restart speed not taken");
	chk_auto_inhibit: assert property (!s.start_opt[0] && !s.armed && !hw_rise &&
		s.mode == drive_ctrl_pkg::ST_STOP |=> !motor_run) // see (R08)
		else $error("auto start while inhibited");
	chk_dir_input_four: assert property (s.term_cfg <= `CFG_DIR_ONLY_MAX ##1
		$stable(s.term_cfg) |-> dir_ccw == $past(input_four)) // see (R10)
		else $error("direction does not follow input four");
	chk_power_on_both: assert property (s.term_cfg > `CFG_DIR_ONLY_MAX && !s.dir_seen &&
		input_three && input_four |=> quickstop) // see (R12)
		else $error("no quickstop with both inputs at power-on");
	chk_fmax_limit: assert property (##1 setpoint_out <= $past(s.fmax)) // see (R13)
		else $error("setpoint above maximum");
	chk_mpot_zero: assert property (s.nv_loaded && mpot_active && !input_one && !input_two
		|=> s.mpot == 13'h0000) // see (R17)
		else $error("motor pot not forced to zero");
	chk_qstop_clears_mpot: assert property (s.nv_loaded && s.ctrl_ext && q_now
		|=> s.mpot == 13'h0000 && quickstop) // see (R19)
		else $error("quickstop kept motor pot value");

endmodule

`default_nettype wire

// File: verif/drive_far_side_model.sv
// Far-side model: coasting speed sensor and nonvolatile motor-pot store
`timescale 1ns/1ns
`default_nettype none
module drive_far_side_model #(
	parameter logic [12:0] COAST_SPEED = 13'h00c8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic slow,
	input wire logic speed_catch_req,
	input wire logic [12:0] nv_mpot_out,
	output logic speed_valid,
	output logic [12:0] speed_meas,
	output logic [12:0] nv_mpot_in
);
	logic [3:0] wait_cnt;
	logic [1:0] boot_cnt;
	logic [12:0] nv_mem = 13'h0000;
	assign nv_mpot_in = nv_mem;
	// Store ignores the block's reset; skip edges before the restore lands
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			boot_cnt <= 2'h0;
		end else if (boot_cnt != 2'h2) begin
			boot_cnt <= boot_cnt + 2'h1;
		end else begin
			nv_mem <= nv_mpot_out;
		end
	end
	// Speed line toggles while not valid so stale data never looks good
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wait_cnt <= 4'h0;
			speed_valid <= 1'b0;
			speed_meas <= 13'h0000;
		end else if (speed_catch_req && wait_cnt != (slow ? 4'h6 : 4'h1)) begin
			wait_cnt <= wait_cnt + 4'h1;
			speed_valid <= 1'b0;
			speed_meas <= ~speed_meas;
		end else if (speed_catch_req) begin
			speed_valid <= 1'b1;
			speed_meas <= COAST_SPEED;
		end else begin
			wait_cnt <= 4'h0;
			speed_valid <= 1'b0;
			speed_meas <= ~speed_meas;
		end
	end
endmodule
`default_nettype wire

// File: verif/drive_run_enable_setpoint_ctrl_bench.sv
// Self-checking bench for the run-enable and setpoint block
`include "drive_ctrl_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module drive_run_enable_setpoint_ctrl_bench;
	logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b1, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, m, rng = 32'h36f5;
	logic [1:0] htrans = 2'h0;
	logic hw_enable = 1'b0, input_one = 1'b0, input_two = 1'b0;
	logic input_three = 1'b0, input_four = 1'b0, keypad_present = 1'b0;
	logic key_run = 1'b0, key_stop = 1'b0, fault_trip = 1'b0;
	logic hreadyout, hresp, motor_run, speed_catch_req, dir_ccw, quickstop, speed_valid;
	logic [31:0] hrdata;
	logic [12:0] nv_mpot_in, nv_mpot_out, ramp_start_freq, setpoint_out, speed_meas;
	logic [31:0] exp_q[$], obs_q[$];
	string name_q[$];
	int err_total = 0, check_count = 0;
	always #20 clk = ~clk;
	drive_run_enable_setpoint_ctrl #(.STEP_CYCLES(16'h0004)) dut_u (.clk(clk),
		.sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .hw_enable(hw_enable), .input_one(input_one),
		.input_two(input_two), .input_three(input_three), .input_four(input_four),
		.keypad_present(keypad_present), .key_run(key_run), .key_stop(key_stop),
		.fault_trip(fault_trip), .speed_valid(speed_valid), .speed_meas(speed_meas),
		.nv_mpot_in(nv_mpot_in), .nv_mpot_out(nv_mpot_out), .motor_run(motor_run),
		.speed_catch_req(speed_catch_req), .ramp_start_freq(ramp_start_freq),
		.dir_ccw(dir_ccw), .quickstop(quickstop), .setpoint_out(setpoint_out));
	drive_far_side_model far_u (.clk(clk), .sys_rst(sys_rst), .slow(1'b1),
		.speed_catch_req(speed_catch_req), .nv_mpot_out(nv_mpot_out),
		.speed_valid(speed_valid), .speed_meas(speed_meas), .nv_mpot_in(nv_mpot_in));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		name_q.push_back(nm);
		exp_q.push_back(e);
		obs_q.push_back(v);
	endtask
	task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
		@(posedge clk);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, idx, 2'b00};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdc(input string nm, input logic [5:0] idx, input logic [31:0] e);
		bus(1'b0, idx, 32'h0);
		chk(nm, e, rd);
	endtask
	task automatic press(input logic stop);
		@(posedge clk) begin
			key_stop <= stop;
			key_run <= !stop;
		end
		@(posedge clk) begin
			key_stop <= 1'b0;
			key_run <= 1'b0;
		end
		wt(2);
	endtask
	task automatic end_sim;
		wait (obs_q.size() == 0);
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Watcher pairs each observation with the oldest expectation
	initial forever begin
		wait (obs_q.size() != 0);
		check_count++;
		if (obs_q[0] !== exp_q[0]) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name_q[0], exp_q[0], obs_q[0]);
		end
		void'(obs_q.pop_front());
		void'(exp_q.pop_front());
		void'(name_q.pop_front());
	end
	initial begin
		#400000;
		err_total++;
		end_sim;
	end
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		rdc("start_opt", `REG_START_OPT, 32'h1);
		rdc("fset", `REG_FSET, 32'h0);
		bus(1'b1, `REG_FSET, 32'h1388);
		rdc("fset_basic", `REG_FSET, 32'h1388);
		@(posedge clk) hw_enable <= 1'b1;
		wt(2);
		chk("run", 32'h1, 32'(motor_run));
		chk("setpoint", 32'h1f4, 32'(setpoint_out));
		chk("hresp", 32'h0, 32'(hresp));
		bus(1'b1, `REG_FSET, 32'h000a);
		rdc("fset_locked", `REG_FSET, 32'h1388);
		for (int i = 0; i < 6; i++) begin
			rng = xs(rng);
			@(posedge clk) input_four <= rng[0];
			wt(2);
			chk("dir", 32'(rng[0]), 32'(dir_ccw));
		end
		@(posedge clk) keypad_present <= 1'b1;
		press(1'b1);
		chk("kp_stop", 32'h0, 32'(motor_run));
		@(posedge clk) keypad_present <= 1'b0;
		press(1'b0);
		chk("kp_gone", 32'h0, 32'(motor_run));
		@(posedge clk) keypad_present <= 1'b1;
		press(1'b0);
		chk("kp_run", 32'h1, 32'(motor_run));
		@(posedge clk) begin
			keypad_present <= 1'b0;
			hw_enable <= 1'b0;
		end
		wt(2);
		chk("en_low", 32'h0, 32'(motor_run));
		bus(1'b1, `REG_START_OPT, 32'h0);
		@(posedge clk) hw_enable <= 1'b1;
		wt(2);
		chk("armed", 32'h1, 32'(motor_run));
		@(posedge clk) fault_trip <= 1'b1;
		@(posedge clk) fault_trip <= 1'b0;
		wt(2);
		chk("after_fault", 32'h0, 32'(motor_run));
		@(posedge clk) hw_enable <= 1'b0;
		@(posedge clk) hw_enable <= 1'b1;
		wt(2);
		chk("rearmed", 32'h1, 32'(motor_run));
		@(posedge clk) hw_enable <= 1'b0;
		bus(1'b1, `REG_START_OPT, 32'h2);
		@(posedge clk) hw_enable <= 1'b1;
		wt(2);
		chk("catch", 32'h1, 32'(speed_catch_req));
		chk("no_power", 32'h0, 32'(motor_run));
		for (int i = 0; i < 20 && motor_run !== 1'b1; i++) wt(0);
		chk("ramp_start", 32'h0c8, 32'(ramp_start_freq));
		@(posedge clk) hw_enable <= 1'b0;
		bus(1'b1, `REG_START_OPT, 32'h1);
		bus(1'b1, `REG_CTRL, 32'h2);
		@(posedge clk) hw_enable <= 1'b1;
		wt(2);
		chk("sw_off", 32'h0, 32'(motor_run));
		bus(1'b1, `REG_CMD_WORD, 32'h200);
		wt(2);
		chk("cmd_en", 32'h1, 32'(motor_run));
		@(posedge clk) hw_enable <= 1'b0;
		bus(1'b1, `REG_CMD_WORD, 32'h0);
		bus(1'b1, `REG_CTRL, 32'h6);
		@(posedge clk) hw_enable <= 1'b1;
		wt(2);
		chk("sw_en", 32'h1, 32'(motor_run));
		@(posedge clk) hw_enable <= 1'b0;
		bus(1'b1, `REG_CTRL, 32'h1);
		bus(1'b1, `REG_TERM_CFG, 32'ha);
		bus(1'b1, `REG_FSET, 32'h1388);
		rdc("fset_ext", `REG_FSET, 32'h1f4);
		@(posedge clk) input_two <= 1'b1;
		wt(30);
		@(posedge clk) input_one <= 1'b1;
		wt(2);
		bus(1'b0, `REG_MPOT, 32'h0);
		m = rd;
		chk("mpot_up", 32'h1, 32'(m != 32'h0));
		wt(12);
		rdc("mpot_freeze", `REG_MPOT, m);
		@(posedge clk) sys_rst <= 1'b1;
		@(posedge clk) sys_rst <= 1'b0;
		wt(3);
		rdc("mpot_kept", `REG_MPOT, m);
		bus(1'b1, `REG_CTRL, 32'h1);
		bus(1'b1, `REG_TERM_CFG, 32'he);
		@(posedge clk) begin
			hw_enable <= 1'b1;
			input_three <= 1'b1;
			input_four <= 1'b0;
		end
		wt(2);
		chk("dir_cw", 32'h0, 32'(dir_ccw));
		@(posedge clk) begin
			input_three <= 1'b0;
			input_four <= 1'b1;
		end
		wt(2);
		chk("dir_ccw", 32'h1, 32'(dir_ccw));
		@(posedge clk) input_three <= 1'b1;
		wt(2);
		chk("dir_hold", 32'h1, 32'(dir_ccw));
		@(posedge clk) begin
			input_three <= 1'b0;
			input_four <= 1'b0;
		end
		wt(2);
		chk("qstop", 32'h1, 32'(quickstop));
		rdc("mpot_qstop", `REG_MPOT, 32'h0);
		end_sim;
	end
endmodule
`default_nettype wire
